// *** verification/aemi_mem_model.sv ***
// Behavioural external memory on the multiplexed bus.
// Assumes one-hot active-low selects and a latch strobe before data.
`timescale 1ns/1ns
module aemi_mem_model (
    // Clock
    input wire logic clk,
    // Memory pins
    input wire logic [15:0] ad_out,
    input wire logic ad_oe,
    input wire logic a16,
    input wire logic [3:0] sel_n,
    input wire logic ws_n,
    input wire logic rs_n,
    input wire logic ale,
    // Returned bus and latched address
    output logic [15:0] ad_in,
    output logic [16:0] addr_lat
);
    logic [15:0] mem [4][256];
    logic [1:0] rg_ff = 2'h0;
    logic [15:0] last_ff = 16'h0000;

    always_ff @(posedge clk) begin
        last_ff <= ad_in;
        if (ale) begin
            addr_lat <= {a16, ad_out};
            rg_ff <= !sel_n[0] ? 2'h0 : !sel_n[1] ? 2'h1 :
                     !sel_n[2] ? 2'h2 : 2'h3;
        end
        if (!ws_n) begin
            mem[rg_ff][addr_lat[7:0]] <= ad_out;
        end
    end

    // Released bus shows the inverse of its last value
    assign ad_in = (!rs_n && !ad_oe && sel_n != 4'hf) ?
        mem[rg_ff][addr_lat[7:0]] : ~last_ff;
endmodule : aemi_mem_model

// *** verification/tb.sv ***
// Self-checking bench for the external memory interface.
// Assumes the memory model answers while the read strobe is low.
`timescale 1ns/1ns
module tb;
    import aemi_pkg::*;
    typedef struct packed {
        logic w; logic [7:0] o; logic [15:0] d; logic [15:0] e; logic er;
    } aemi_rrow_t;
    typedef struct packed {
        logic [1:0] rg; logic [7:0] ct; logic [15:0] tm;
        logic [15:0] of; logic [15:0] d; logic [1:0] bw;
    } aemi_mrow_t;
    logic clk = 0, rst = 1, req = 0, wr = 0, ready, done, err, ad_oe, a16;
    logic ws_n, rs_n, ale, hbe_n, lbe_n;
    logic [31:0] addr = 32'h0;
    logic [15:0] wdata = 16'h0, rdata, ad_in, ad_out, rd;
    logic [1:0] be = 2'h3, be_seen;
    logic [3:0] sel_n, sel_seen;
    logic [16:0] lat;
    logic er;
    int n_fail = 0, n_tests = 0, n, ale_c, ws_c, rs_c, w, h, tw, tr;
    aemi_rrow_t rr [13] = '{
        '{0, 8'h00, 0, 16'h0000, 0}, '{0, 8'h10, 0, 16'h0000, 0},
        '{0, 8'h1c, 0, 16'h0000, 0}, '{0, 8'h20, 0, 16'h70ff, 0},
        '{0, 8'h2c, 0, 16'h70ff, 0}, '{0, 8'h04, 0, 16'h0000, 1},
        '{1, 8'h24, 16'hffff, 0, 0}, '{0, 8'h24, 0, 16'hf7ff, 0},
        '{1, 8'h14, 16'h00ff, 0, 0}, '{0, 8'h14, 0, 16'h0003, 0},
        '{1, 8'h00, 16'h00ff, 0, 0}, '{0, 8'h00, 0, 16'h0001, 0},
        '{0, 8'h20, 0, 16'h70ff, 0}};
    aemi_mrow_t mr [4] = '{
        '{0, 8'h03, 16'h70ff, 16'h0010, 16'ha55a, 2'b00},
        '{1, 8'h03, 16'h0702, 16'hfffe, 16'h1234, 2'b10},
        '{2, 8'h01, 16'h3053, 16'h0101, 16'h00c3, 2'b11},
        '{3, 8'h01, 16'h8432, 16'h0005, 16'h007e, 2'b01}};

    aemi_top u_dut (.MCLK(clk), .RST(rst), .BUS_REQ(req), .BUS_WR(wr),
        .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_BE(be), .BUS_READY(ready),
        .BUS_DONE(done), .BUS_ERR(err), .BUS_RDATA(rdata), .AD_IN(ad_in),
        .AD_OUT(ad_out), .AD_OE(ad_oe), .EXTRA_HIGH_ADDR_LINE(a16),
        .REGION_SELECT_N(sel_n), .WRITE_STROBE_OUT_N(ws_n),
        .READ_STROBE_OUT_N(rs_n), .ADDR_LATCH_STROBE(ale),
        .HIGH_BYTE_ENABLE_N(hbe_n), .LOW_BYTE_ENABLE_N(lbe_n));
    aemi_mem_model u_mem (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe),
        .a16(a16), .sel_n(sel_n), .ws_n(ws_n), .rs_n(rs_n), .ale(ale),
        .ad_in(ad_in), .addr_lat(lat));

    initial begin
        forever #2 clk = ~clk;
    end

    // Pin activity seen during the current access
    always @(posedge clk) begin
        if (req) begin
            ale_c = 0;
            ws_c = 0;
            rs_c = 0;
            sel_seen = 4'h0;
            be_seen = 2'h3;
        end else begin
            ale_c += ale;
            ws_c += !ws_n;
            rs_c += !rs_n;
            sel_seen |= ~sel_n;
            if (!ws_n) begin
                be_seen = {hbe_n, lbe_n};
            end
        end
    end

    task conclude;
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk

    task acc(input logic w_i, input logic [31:0] a, input logic [15:0] d);
        @(negedge clk);
        req = 1;
        wr = w_i;
        addr = a;
        wdata = d;
        @(negedge clk);
        req = 0;
        n = 1;
        while (done !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        rd = rdata;
        er = err;
        if (n >= 100) begin
            n_fail++;
            conclude();
        end
    endtask : acc

    initial begin
        repeat (8) @(negedge clk);
        rst = 0;
        foreach (rr[i]) begin
            acc(rr[i].w, 32'hfffff000 | rr[i].o, rr[i].d);
            chk(n, 1);
            chk(er, rr[i].er);
            if (!rr[i].w) chk(rd, rr[i].e);
        end
        foreach (mr[i]) begin
            acc(1, 32'hfffff010 + 4 * mr[i].rg, mr[i].ct);
            acc(1, 32'hfffff020 + 4 * mr[i].rg, mr[i].tm);
            w = mr[i].tm[14:12];
            h = !mr[i].tm[10];
            tw = !mr[i].tm[8];
            tr = !mr[i].tm[9];
            addr = {mr[i].rg + 4'h1, 12'h000, mr[i].of};
            be = ~mr[i].bw;
            acc(1, addr, mr[i].d);
            chk(n, 3 + w + h + 2 * tw + mr[i].tm[7:4]);
            chk(er, 0);
            chk(ready, 1);
            chk(sel_seen, 4'h1 << mr[i].rg);
            chk(ale_c, 1 + w);
            chk(ws_c, mr[i].tm[7:4] + 1);
            chk(be_seen, mr[i].bw);
            chk(lat, {1'b0, mr[i].of});
            acc(0, addr, 16'h0);
            chk(n, 3 + w + h + 2 * tr + mr[i].tm[3:0]);
            chk(rs_c, mr[i].tm[3:0] + 1);
            chk(rd & (mr[i].ct[1] ? 16'hffff : 16'h00ff),
                mr[i].d);
        end
        acc(1, 32'hfffff014, 16'h0000);
        acc(1, 32'h20000000, 16'h1111);
        chk({n[7:0], er, sel_seen, ws_c[3:0]}, {8'h1, 1'b1, 8'h0});
        acc(0, 32'h10010000, 16'h0);
        chk({er, sel_seen, rs_c[3:0]}, {1'b1, 8'h0});
        acc(0, 32'hfffff000, 16'h0);
        chk(rd, 16'h0081);
        acc(1, 32'hfffff000, 16'h0000);
        acc(0, 32'h10000010, 16'h0);
        chk({er, sel_seen, rs_c[3:0]}, {1'b1, 8'h0});
        acc(0, 32'hfffff000, 16'h0);
        chk(rd, 16'h0080);
        @(negedge clk);
        rst = 1;
        repeat (8) @(negedge clk);
        rst = 0;
        acc(0, 32'hfffff010, 16'h0);
        chk(rd, 16'h0000);
        acc(0, 32'hfffff02c, 16'h0);
        chk(rd, 16'h70ff);
        conclude();
    end
endmodule : tb

// *** verilog/aemi_pkg.sv ***
// Package for the external asynchronous memory interface.
// Assumes a single system clock and a synchronous active-high reset.
package aemi_pkg;

    localparam int AD_W = 16;
    localparam int NUM_RGN = 4;
    localparam int RGN_OFS_W = 16;

    // Register addresses
    localparam logic [31:0] ADDR_GLOBAL = 32'hfffff000;
    localparam logic [31:0] ADDR_CTRL [NUM_RGN] = '{
        32'hfffff010, 32'hfffff014, 32'hfffff018, 32'hfffff01c};
    localparam logic [31:0] ADDR_TIME [NUM_RGN] = '{
        32'hfffff020, 32'hfffff024, 32'hfffff028, 32'hfffff02c};
    localparam logic [23:0] REG_PAGE = 24'hfffff0;

    // Region base tags, address bits 31:28
    localparam logic [3:0] RGN_TAG [NUM_RGN] = '{
        4'h1, 4'h2, 4'h3, 4'h4};

    // Reset values
    localparam logic [7:0] GLOBAL_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] TIM_RST = 16'h70ff;

    // Field positions
    localparam int GLB_EN_BIT = 0;
    localparam int GLB_REFUSED_BIT = 7;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_W16_BIT = 1;
    localparam int TIM_BYTEWS_BIT = 15;
    localparam int TIM_ALEW_HI = 14;
    localparam int TIM_ALEW_LO = 12;
    localparam int TIM_NOHOLD_BIT = 10;
    localparam int TIM_NORDTURN_BIT = 9;
    localparam int TIM_NOWRTURN_BIT = 8;
    localparam int TIM_WRLEN_HI = 7;
    localparam int TIM_WRLEN_LO = 4;
    localparam int TIM_RDLEN_HI = 3;
    localparam int TIM_RDLEN_LO = 0;

    // Writable bit masks, reserved bits read zero
    localparam logic [7:0] GLB_WR_MASK = 8'h01;
    localparam logic [7:0] CTRL_WR_MASK = 8'h03;
    localparam logic [15:0] TIM_WR_MASK = 16'hf7ff;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_HOLD = 3'b010,
        ST_PRE = 3'b011,
        ST_STRB = 3'b100,
        ST_POST = 3'b101
    } aemi_state_t;

    typedef struct packed {
        logic wr;
        logic [1:0] region;
        logic [16:0] addr;
        logic [15:0] wdata;
        logic [1:0] be;
        logic w16;
        logic [15:0] tim;
    } aemi_acc_t;

    typedef struct packed {
        logic [15:0] ad;
        logic ad_oe;
        logic a16;
        logic [3:0] ms_n;
        logic ws_n;
        logic rs_n;
        logic ale;
        logic bhe_n;
        logic ble_n;
    } aemi_pins_t;

endpackage : aemi_pkg

// *** verilog/aemi_sync.sv ***
// Two-flop synchroniser for the multiplexed address/data input pins.
// Assumes the pins are asynchronous to the system clock.
`timescale 1ns/1ns
module aemi_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [aemi_pkg::AD_W-1:0] din,
    output logic [aemi_pkg::AD_W-1:0] dout
);
    import aemi_pkg::*;

    logic [AD_W-1:0] meta_ff;
    logic [AD_W-1:0] sync_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule : aemi_sync

// *** verilog/aemi_top.sv ***
// External asynchronous memory interface: register file and bus sequencer.
// Assumes a core access port on MCLK; memory pins are asynchronous.
`timescale 1ns/1ns
module aemi_top (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Core access port
    input wire logic BUS_REQ,
    input wire logic BUS_WR,
    input wire logic [31:0] BUS_ADDR,
    input wire logic [15:0] BUS_WDATA,
    input wire logic [1:0] BUS_BE,
    output logic BUS_READY,
    output logic BUS_DONE,
    output logic BUS_ERR,
    output logic [15:0] BUS_RDATA,
    // Memory bus pins
    input wire logic [aemi_pkg::AD_W-1:0] AD_IN,
    output logic [aemi_pkg::AD_W-1:0] AD_OUT,
    output logic AD_OE,
    output logic EXTRA_HIGH_ADDR_LINE,
    output logic [3:0] REGION_SELECT_N,
    output logic WRITE_STROBE_OUT_N,
    output logic READ_STROBE_OUT_N,
    output logic ADDR_LATCH_STROBE,
    output logic HIGH_BYTE_ENABLE_N,
    output logic LOW_BYTE_ENABLE_N
);
    import aemi_pkg::*;

    logic [7:0] glob_ff;
    logic [7:0] nxt_glob;
    wire logic [7:0] ctrl_q [NUM_RGN];
    wire logic [15:0] tim_q [NUM_RGN];
    aemi_state_t state_ff;
    aemi_state_t nxt_state;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    aemi_acc_t acc_ff;
    aemi_acc_t nxt_acc;
    aemi_pins_t pins_ff;
    aemi_pins_t nxt_pins;
    logic done_ff;
    logic nxt_done;
    logic err_ff;
    logic nxt_err;
    logic ready_ff;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic [AD_W-1:0] ad_sync;

    logic [NUM_RGN-1:0] rgn_hit;
    logic [NUM_RGN-1:0] ctrl_sel;
    logic [NUM_RGN-1:0] tim_sel;
    logic is_reg;
    logic is_mem;
    logic glob_sel;
    logic reg_known;
    logic reg_wr;
    logic mem_ok;
    logic [1:0] hit_rgn;
    logic [15:0] reg_rd;
    logic turn;
    logic [3:0] slen;

    aemi_sync u_sync (
        .clk(MCLK),
        .rst(RST),
        .din(AD_IN),
        .dout(ad_sync)
    );

    assign is_reg = BUS_ADDR[31:8] == REG_PAGE;
    assign glob_sel = BUS_ADDR == ADDR_GLOBAL;
    assign reg_known = glob_sel | (|ctrl_sel) | (|tim_sel);
    assign reg_wr = ready_ff & BUS_REQ & BUS_WR & is_reg;
    assign is_mem = |rgn_hit;

    // Per-region decode and configuration storage
    genvar g;
    for (g = 0; g < NUM_RGN; g++) begin : g_rgn
        logic [7:0] ctrl_ff;
        logic [7:0] nxt_ctrl;
        logic [15:0] tim_ff;
        logic [15:0] nxt_tim;

        // 64 kB window per region
        assign rgn_hit[g] = BUS_ADDR[31:28] == RGN_TAG[g]
            && BUS_ADDR[27:RGN_OFS_W] == '0;
        assign ctrl_sel[g] = BUS_ADDR == ADDR_CTRL[g];
        assign tim_sel[g] = BUS_ADDR == ADDR_TIME[g];
        assign ctrl_q[g] = ctrl_ff;
        assign tim_q[g] = tim_ff;

        always_comb begin
            nxt_ctrl = ctrl_ff;
            nxt_tim = tim_ff;
            if (reg_wr && ctrl_sel[g]) begin
                nxt_ctrl = BUS_WDATA[7:0] & CTRL_WR_MASK;
            end
            if (reg_wr && tim_sel[g]) begin
                nxt_tim = BUS_WDATA & TIM_WR_MASK;
            end
        end

        always_ff @(posedge MCLK) begin
            if (RST) begin
                ctrl_ff <= CTRL_RST;
                tim_ff <= TIM_RST;
            end else begin
                ctrl_ff <= nxt_ctrl;
                tim_ff <= nxt_tim;
            end
        end
    end

    // Region index and register read mux
    always_comb begin
        hit_rgn = 2'd0;
        reg_rd = 16'h0000;
        if (glob_sel) begin
            reg_rd = {8'h00, glob_ff};
        end
        for (int i = 0; i < NUM_RGN; i++) begin
            if (rgn_hit[i]) begin
                hit_rgn = 2'(i);
            end
            if (ctrl_sel[i]) begin
                reg_rd = {8'h00, ctrl_q[i]};
            end
            if (tim_sel[i]) begin
                reg_rd = tim_q[i];
            end
        end
    end

    assign mem_ok = is_mem && glob_ff[GLB_EN_BIT]
        && ctrl_q[hit_rgn][CTRL_EN_BIT];

    // Global register: enable plus sticky refused flag
    always_comb begin
        nxt_glob = glob_ff;
        if (reg_wr && glob_sel) begin
            nxt_glob = BUS_WDATA[7:0] & GLB_WR_MASK;
        end
        if (ready_ff && BUS_REQ && !is_reg && !mem_ok) begin
            nxt_glob[GLB_REFUSED_BIT] = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            glob_ff <= GLOBAL_RST;
        end else begin
            glob_ff <= nxt_glob;
        end
    end

    assign turn = acc_ff.wr ? !acc_ff.tim[TIM_NOWRTURN_BIT]
        : !acc_ff.tim[TIM_NORDTURN_BIT];
    assign slen = acc_ff.wr ? acc_ff.tim[TIM_WRLEN_HI:TIM_WRLEN_LO]
        : acc_ff.tim[TIM_RDLEN_HI:TIM_RDLEN_LO];

    // Access sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_acc = acc_ff;
        nxt_done = 1'b0;
        nxt_err = 1'b0;
        nxt_rdata = rdata_ff;
        case (state_ff)
            ST_IDLE: begin
                if (BUS_REQ) begin
                    if (is_reg) begin
                        nxt_done = 1'b1;
                        nxt_err = !reg_known;
                        if (!BUS_WR) begin
                            nxt_rdata = reg_rd;
                        end
                    end else if (mem_ok) begin
                        nxt_acc.wr = BUS_WR;
                        nxt_acc.region = hit_rgn;
                        nxt_acc.addr = BUS_ADDR[16:0];
                        nxt_acc.wdata = BUS_WDATA;
                        nxt_acc.be = BUS_BE;
                        nxt_acc.w16 = ctrl_q[hit_rgn][CTRL_W16_BIT];
                        nxt_acc.tim = tim_q[hit_rgn];
                        nxt_cnt = {1'b0,
                            tim_q[hit_rgn][TIM_ALEW_HI:TIM_ALEW_LO]};
                        nxt_state = ST_ADDR;
                    end else begin
                        nxt_done = 1'b1;
                        nxt_err = 1'b1;
                    end
                end
            end
            ST_ADDR: begin
                if (cnt_ff != 4'h0) begin
                    nxt_cnt = cnt_ff - 4'h1;
                end else if (!acc_ff.tim[TIM_NOHOLD_BIT]) begin
                    nxt_state = ST_HOLD;
                end else if (turn) begin
                    nxt_state = ST_PRE;
                end else begin
                    nxt_state = ST_STRB;
                    nxt_cnt = slen;
                end
            end
            ST_HOLD: begin
                if (turn) begin
                    nxt_state = ST_PRE;
                end else begin
                    nxt_state = ST_STRB;
                    nxt_cnt = slen;
                end
            end
            ST_PRE: begin
                nxt_state = ST_STRB;
                nxt_cnt = slen;
            end
            ST_STRB: begin
                if (cnt_ff != 4'h0) begin
                    nxt_cnt = cnt_ff - 4'h1;
                end else begin
                    if (!acc_ff.wr) begin
                        nxt_rdata = acc_ff.w16 ? ad_sync
                            : {8'h00, ad_sync[7:0]};
                    end
                    if (turn) begin
                        nxt_state = ST_POST;
                    end else begin
                        nxt_state = ST_IDLE;
                        nxt_done = 1'b1;
                    end
                end
            end
            ST_POST: begin
                nxt_state = ST_IDLE;
                nxt_done = 1'b1;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Pin values follow the next state so pins leave flops aligned
    always_comb begin
        nxt_pins = '0;
        nxt_pins.ms_n = 4'hf;
        nxt_pins.ws_n = 1'b1;
        nxt_pins.rs_n = 1'b1;
        nxt_pins.bhe_n = 1'b1;
        nxt_pins.ble_n = 1'b1;
        if (nxt_state != ST_IDLE) begin
            nxt_pins.ms_n[nxt_acc.region] = 1'b0;
            nxt_pins.a16 = !nxt_acc.w16 && nxt_acc.addr[16];
            if (nxt_acc.w16 && !nxt_acc.tim[TIM_BYTEWS_BIT]) begin
                nxt_pins.bhe_n = !nxt_acc.be[1];
                nxt_pins.ble_n = !nxt_acc.be[0];
            end
        end
        case (nxt_state)
            ST_ADDR: begin
                nxt_pins.ad = nxt_acc.addr[15:0];
                nxt_pins.ad_oe = 1'b1;
                nxt_pins.ale = 1'b1;
            end
            ST_HOLD: begin
                nxt_pins.ad = nxt_acc.addr[15:0];
                nxt_pins.ad_oe = 1'b1;
            end
            ST_PRE, ST_STRB, ST_POST: begin
                if (nxt_acc.wr) begin
                    nxt_pins.ad_oe = 1'b1;
                    nxt_pins.ad = nxt_acc.w16 ? nxt_acc.wdata
                        : {8'h00, nxt_acc.wdata[7:0]};
                end
                if (nxt_state == ST_STRB) begin
                    nxt_pins.ws_n = !nxt_acc.wr;
                    nxt_pins.rs_n = nxt_acc.wr;
                    if (nxt_acc.wr && nxt_acc.tim[TIM_BYTEWS_BIT]) begin
                        nxt_pins.ble_n = nxt_acc.addr[0];
                        nxt_pins.bhe_n = !nxt_acc.addr[0];
                    end
                end
            end
            default: begin
                nxt_pins.ad_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            acc_ff <= '0;
            pins_ff <= '{ad: 16'h0000, ad_oe: 1'b0, a16: 1'b0,
                ms_n: 4'hf, ws_n: 1'b1, rs_n: 1'b1, ale: 1'b0,
                bhe_n: 1'b1, ble_n: 1'b1};
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            ready_ff <= 1'b1;
            rdata_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            acc_ff <= nxt_acc;
            pins_ff <= nxt_pins;
            done_ff <= nxt_done;
            err_ff <= nxt_err;
            ready_ff <= nxt_state == ST_IDLE;
            rdata_ff <= nxt_rdata;
        end
    end

    assign BUS_READY = ready_ff;
    assign BUS_DONE = done_ff;
    assign BUS_ERR = err_ff;
    assign BUS_RDATA = rdata_ff;
    assign AD_OUT = pins_ff.ad;
    assign AD_OE = pins_ff.ad_oe;
    assign EXTRA_HIGH_ADDR_LINE = pins_ff.a16;
    assign REGION_SELECT_N = pins_ff.ms_n;
    assign WRITE_STROBE_OUT_N = pins_ff.ws_n;
    assign READ_STROBE_OUT_N = pins_ff.rs_n;
    assign ADDR_LATCH_STROBE = pins_ff.ale;
    assign HIGH_BYTE_ENABLE_N = pins_ff.bhe_n;
    assign LOW_BYTE_ENABLE_N = pins_ff.ble_n;

    // Strobe run-length counters for checking
    logic [4:0] ale_run_ff;
    logic [4:0] ws_run_ff;
    logic [4:0] rs_run_ff;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ale_run_ff <= 5'd0;
            ws_run_ff <= 5'd0;
            rs_run_ff <= 5'd0;
        end else begin
            ale_run_ff <= ADDR_LATCH_STROBE ? ale_run_ff + 5'd1 : 5'd0;
            ws_run_ff <= !WRITE_STROBE_OUT_N ? ws_run_ff + 5'd1 : 5'd0;
            rs_run_ff <= !READ_STROBE_OUT_N ? rs_run_ff + 5'd1 : 5'd0;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    property p_addr_low16;
        ADDR_LATCH_STROBE |-> AD_OE && AD_OUT == acc_ff.addr[15:0];
    endproperty
    a_addr_low16: assert property (p_addr_low16)
        else $error("address phase does not show low address bits");

    property p_one_select;
        REGION_SELECT_N == (ready_ff ? 4'hf : ~(4'h1 << acc_ff.region));
    endproperty
    a_one_select: assert property (p_one_select)
        else $error("more than one region select asserted");

    property p_refused;
        (ready_ff && BUS_REQ && !is_reg && !mem_ok) |=>
            BUS_DONE && BUS_ERR && REGION_SELECT_N == 4'hf
            && READ_STROBE_OUT_N && WRITE_STROBE_OUT_N ##1
            REGION_SELECT_N == 4'hf;
    endproperty
    a_refused: assert property (p_refused)
        else $error("refused access touched the memory pins");

    property p_ale_len;
        $fell(ADDR_LATCH_STROBE) |->
            ale_run_ff == 5'(acc_ff.tim[TIM_ALEW_HI:TIM_ALEW_LO]) + 5'd1;
    endproperty
    a_ale_len: assert property (p_ale_len)
        else $error("address latch strobe length wrong");

    property p_ws_len;
        $rose(WRITE_STROBE_OUT_N) |->
            ws_run_ff == 5'(acc_ff.tim[TIM_WRLEN_HI:TIM_WRLEN_LO]) + 5'd1;
    endproperty
    a_ws_len: assert property (p_ws_len)
        else $error("write strobe length wrong");

    property p_rs_len;
        $rose(READ_STROBE_OUT_N) |->
            rs_run_ff == 5'(acc_ff.tim[TIM_RDLEN_HI:TIM_RDLEN_LO]) + 5'd1;
    endproperty
    a_rs_len: assert property (p_rs_len)
        else $error("read strobe length wrong");

    property p_hold;
        ($fell(ADDR_LATCH_STROBE) && !acc_ff.tim[TIM_NOHOLD_BIT]) |->
            AD_OE && AD_OUT == acc_ff.addr[15:0]
            && READ_STROBE_OUT_N && WRITE_STROBE_OUT_N;
    endproperty
    a_hold: assert property (p_hold)
        else $error("address hold cycle missing");

    property p_rd_turn;
        ($rose(READ_STROBE_OUT_N) && !acc_ff.tim[TIM_NORDTURN_BIT]) |->
            REGION_SELECT_N != 4'hf && !BUS_DONE ##1 BUS_DONE;
    endproperty
    a_rd_turn: assert property (p_rd_turn)
        else $error("read turnaround cycle missing");

    property p_wr_turn;
        ($rose(WRITE_STROBE_OUT_N) && !acc_ff.tim[TIM_NOWRTURN_BIT]) |->
            AD_OE && !BUS_DONE ##1 BUS_DONE;
    endproperty
    a_wr_turn: assert property (p_wr_turn)
        else $error("write turnaround cycle missing");

    property p_read_release;
        !READ_STROBE_OUT_N |-> !AD_OE && !ADDR_LATCH_STROBE;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("bus driven during read strobe");

    property p_byte_ws;
        (!WRITE_STROBE_OUT_N && acc_ff.tim[TIM_BYTEWS_BIT]) |->
            LOW_BYTE_ENABLE_N == acc_ff.addr[0]
            && HIGH_BYTE_ENABLE_N == !acc_ff.addr[0];
    endproperty
    a_byte_ws: assert property (p_byte_ws)
        else $error("byte write strobes not gated by address bit");

    property p_narrow;
        (REGION_SELECT_N != 4'hf && acc_ff.w16) |-> !EXTRA_HIGH_ADDR_LINE;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("extra address line used on 16-bit region");

    c_read: cover property ($rose(READ_STROBE_OUT_N) ##[1:2] BUS_DONE);
    c_write: cover property ($rose(WRITE_STROBE_OUT_N) ##[1:2] BUS_DONE);
    c_refused: cover property (BUS_DONE && BUS_ERR);
    c_reg_wr: cover property (reg_wr && tim_sel != '0);

endmodule : aemi_top
